// ===== logic/uart_mcr_pkg.sv
// Package: register map, field layout and timing of the modem control block
//
// Behaviour
// R1: Bit 2 set drives aux output A low
// R2: Processor reset output follows bit 2 uninverted
// R3: Bit 3 set drives aux output B low
// R4: Bit 3 enables interrupt pin driver
// R5: Loopback holds serial transmit pin high
// R6: Loopback ignores serial receive pin
// R7: Loopback feeds transmit line into receiver
// R8: Loopback routes control bits to status inputs
// R9: Loopback forces control output pins high
// R10: Loopback keeps receive and transmit interrupts working
// R11: Loopback control bit changes raise modem interrupts
// R12: Bits 5 and 6 always read zero
// R13: Bit 7 in vendor mode stops oscillator
// R14: Power shutdown keeps all register contents
// R15: Clearing bit 7 restarts the port
// R16: Bit 0 set drives terminal ready low
// R17: Bit 1 set drives request to send low
// R18: Loopback maps RTS,DTR,auxA,auxB to CTS,DSR,RI,DCD
// R19: Writes to always-zero bits have no effect
package uart_mcr_pkg;
   // Word address width and word offsets
   localparam int unsigned ADDR_W       = 3;
   localparam logic [2:0]  OFS_MCR      = 3'h0;
   localparam logic [2:0]  OFS_MSR      = 3'h1;
   localparam logic [2:0]  OFS_IRQ_STAT = 3'h2;
   localparam logic [2:0]  OFS_IRQ_MASK = 3'h3;
   localparam logic [2:0]  OFS_DATA     = 3'h4;
   localparam logic [2:0]  OFS_CFG      = 3'h5;
   // Control register fields
   localparam int unsigned B_DTR  = 0;
   localparam int unsigned B_RTS  = 1;
   localparam int unsigned B_AUXA = 2;
   localparam int unsigned B_AUXB = 3;
   localparam int unsigned B_LOOP = 4;
   localparam int unsigned B_PWR  = 7;
   localparam logic [7:0]  MCR_WMASK = 8'h9F;
   localparam logic [7:0]  MCR_RST   = 8'h00;
   // Interrupt status and mask fields
   localparam int unsigned IRQ_W   = 3;
   localparam int unsigned I_MODEM = 0;
   localparam int unsigned I_RX    = 1;
   localparam int unsigned I_TX    = 2;
   localparam logic [2:0]  IRQ_RST = 3'h0;
   // Configuration fields
   localparam int unsigned C_VMODE = 0;
   localparam int unsigned C_BUSY  = 1;
   localparam logic        CFG_RST = 1'b0;
   // Pin input reset levels: dcd_n, ri_n, dsr_n, cts_n, rx
   localparam logic [4:0]  PIN_RST = 5'h1F;
   // Timing: clock cycles per oversample tick, ticks per bit
   localparam int unsigned BAUD_DIV_DEF = 8;
   localparam int unsigned OSR          = 16;
   localparam int unsigned TICK_MAX     = 64;
endpackage

// ===== logic/uart_modem_ctrl_loopback.sv
// Modem control register with loopback, power-down and Avalon-MM access
//
// Decided for this implementation: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
module uart_modem_ctrl_loopback #(
   parameter int unsigned BAUD_DIV = uart_mcr_pkg::BAUD_DIV_DEF
) (
   // Clock and reset
   input  wire logic                            i_clk,
   input  wire logic                            i_nrst,
   // Avalon-MM slave
   input  wire logic [uart_mcr_pkg::ADDR_W-1:0] i_address,
   input  wire logic                            i_read,
   input  wire logic                            i_write,
   input  wire logic [31:0]                     i_writedata,
   input  wire logic [3:0]                      i_byteenable,
   output logic [31:0]                          o_readdata,
   output logic                                 o_waitrequest,
   output logic                                 o_irq,
   // Serial and modem input pins
   input  wire logic                            i_serial_rx_in,
   input  wire logic                            i_cts_n,
   input  wire logic                            i_dsr_n,
   input  wire logic                            i_ri_n,
   input  wire logic                            i_dcd_n,
   // Serial and modem output pins
   output logic                                 o_serial_tx_out,
   output logic                                 o_dtr_n,
   output logic                                 o_rts_n,
   output logic                                 o_aux_output_a_n,
   output logic                                 o_aux_output_b_n,
   output logic                                 o_processor_reset_out,
   output logic                                 o_interrupt_pin_o,
   output logic                                 o_interrupt_pin_oe
);
   import uart_mcr_pkg::*;

   localparam int unsigned DW = (BAUD_DIV < 2) ? 1 : $clog2(BAUD_DIV);

   generate
      if (BAUD_DIV < 1 || BAUD_DIV > TICK_MAX) begin : g_chk
         $error("BAUD_DIV must lie in 1..TICK_MAX");
      end
   endgenerate

   // Registers
   logic [7:0]       mcr_reg;
   logic             vmode_reg;
   logic [IRQ_W-1:0] irq_reg;
   logic [IRQ_W-1:0] mask_reg;
   logic [3:0]       delta_reg;
   logic [3:0]       mstat_reg;
   logic             ack_reg;
   logic [31:0]      rdata_reg;
   logic [DW-1:0]    div_reg;
   logic [4:0]       s1_reg;
   logic [4:0]       s2_reg;
   logic [4:0]       s3_reg;
   logic [4:0]       filt_reg;

   // Next values and decode wires
   logic [7:0]       mcr_next;
   logic [IRQ_W-1:0] irq_next;
   logic [3:0]       delta_next;
   logic [3:0]       delta_ev;
   logic [IRQ_W-1:0] irq_ev;
   logic [3:0]       view;
   logic [7:0]       rd_mux;
   logic [7:0]       rx_data;
   logic             req;
   logic             acc;
   logic             wr_lo;
   logic             rd_acc;
   logic             sel_mcr;
   logic             sel_msr;
   logic             sel_stat;
   logic             sel_mask;
   logic             sel_data;
   logic             sel_cfg;
   logic             loop;
   logic             run;
   logic             tick;
   logic             tx_line;
   logic             tx_busy;
   logic             tx_done;
   logic             rx_src;
   logic             rx_valid;

   // Bus handshake: one wait cycle, then accept
   assign req           = i_read || i_write;
   assign acc           = req && ack_reg;
   assign o_waitrequest = req && !ack_reg;
   assign o_readdata    = rdata_reg;
   assign wr_lo         = acc && i_write && i_byteenable[0];
   assign rd_acc        = acc && i_read;

   // Address decode
   assign sel_mcr  = (i_address == OFS_MCR);
   assign sel_msr  = (i_address == OFS_MSR);
   assign sel_stat = (i_address == OFS_IRQ_STAT);
   assign sel_mask = (i_address == OFS_IRQ_MASK);
   assign sel_data = (i_address == OFS_DATA);
   assign sel_cfg  = (i_address == OFS_CFG);

   // Read data select, unmapped reads zero
   assign rd_mux = sel_mcr  ? mcr_reg :
                   sel_msr  ? {mstat_reg, delta_reg} :
                   sel_stat ? {5'h00, irq_reg} :
                   sel_mask ? {5'h00, mask_reg} :
                   sel_data ? rx_data :
                   sel_cfg  ? {6'h00, tx_busy, vmode_reg} : 8'h00;

   // Control register write, dead bits stay zero
   assign mcr_next = (wr_lo && sel_mcr) ? (i_writedata[7:0] & MCR_WMASK) : mcr_reg; // R12 R19
   assign loop     = mcr_reg[B_LOOP];

   // Oscillator stop only in vendor mode
   assign run  = !(vmode_reg && mcr_reg[B_PWR]); // R13 R15
   assign tick = run && (div_reg == DW'(BAUD_DIV - 1));

   // Loopback serial path
   assign rx_src = loop ? tx_line : filt_reg[0]; // R6 R7

   // Modem status view: cts, dsr, ri, dcd in bits 0..3
   assign view = loop ? {mcr_reg[B_AUXB], mcr_reg[B_AUXA], mcr_reg[B_DTR], mcr_reg[B_RTS]}
                      : ~filt_reg[4:1]; // R8 R18 R11

   // Change events; ring counts on its trailing edge
   assign delta_ev   = {view[3] ^ mstat_reg[3], mstat_reg[2] & ~view[2],
                        view[1:0] ^ mstat_reg[1:0]};
   assign delta_next = (delta_reg & ~{4{rd_acc && sel_msr}}) | delta_ev;

   // Sticky interrupt status, set wins over write-one-clear
   assign irq_ev   = {tx_done, rx_valid, |delta_ev}; // R10 R11
   assign irq_next = (irq_reg & ~((wr_lo && sel_stat) ? i_writedata[IRQ_W-1:0] : '0))
                     | irq_ev;

   // Bus acknowledge and read data capture
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         ack_reg   <= 1'b0;
         rdata_reg <= 32'h0000_0000;
      end else begin
         ack_reg <= req && !ack_reg;
         if (i_read && !ack_reg) rdata_reg <= {24'h00_0000, rd_mux};
      end
   end

   // Software registers, held through power shutdown
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         mcr_reg   <= MCR_RST;
         vmode_reg <= CFG_RST;
         mask_reg  <= IRQ_RST;
         irq_reg   <= IRQ_RST;
      end else begin
         mcr_reg <= mcr_next; // R14
         irq_reg <= irq_next;
         if (wr_lo && sel_cfg) vmode_reg <= i_writedata[C_VMODE];
         if (wr_lo && sel_mask) mask_reg <= i_writedata[IRQ_W-1:0];
      end
   end

   // Modem status tracking
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         mstat_reg <= 4'h0;
         delta_reg <= 4'h0;
      end else begin
         mstat_reg <= view;
         delta_reg <= delta_next;
      end
   end

   // Oversample divider, frozen while powered down
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         div_reg <= '0;
      end else if (run) begin
         div_reg <= tick ? '0 : div_reg + DW'(1);
      end
   end

   // Pin synchroniser: a change counts once stages 2 and 3 agree
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         s1_reg   <= PIN_RST;
         s2_reg   <= PIN_RST;
         s3_reg   <= PIN_RST;
         filt_reg <= PIN_RST;
      end else begin
         s1_reg   <= {i_dcd_n, i_ri_n, i_dsr_n, i_cts_n, i_serial_rx_in};
         s2_reg   <= s1_reg;
         s3_reg   <= s2_reg;
         filt_reg <= (s2_reg & s3_reg) | (filt_reg & (s2_reg ^ s3_reg));
      end
   end

   // Output pins; loopback parks controls inactive and line at mark
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         o_serial_tx_out       <= 1'b1;
         o_dtr_n               <= 1'b1;
         o_rts_n               <= 1'b1;
         o_aux_output_a_n      <= 1'b1;
         o_aux_output_b_n      <= 1'b1;
         o_processor_reset_out <= 1'b0;
         o_interrupt_pin_o     <= 1'b0;
         o_interrupt_pin_oe    <= 1'b0;
         o_irq                 <= 1'b0;
      end else begin
         o_serial_tx_out       <= loop || tx_line; // R5
         o_dtr_n               <= loop || !mcr_reg[B_DTR]; // R16 R9
         o_rts_n               <= loop || !mcr_reg[B_RTS]; // R17 R9
         o_aux_output_a_n      <= loop || !mcr_reg[B_AUXA]; // R1 R9
         o_aux_output_b_n      <= loop || !mcr_reg[B_AUXB]; // R3 R9
         o_processor_reset_out <= mcr_reg[B_AUXA]; // R2
         o_interrupt_pin_oe    <= mcr_reg[B_AUXB]; // R4
         o_interrupt_pin_o     <= |(irq_reg & mask_reg);
         o_irq                 <= |(irq_reg & mask_reg);
      end
   end

   // Transmit shift register
   uart_tx_shift #(
      .OSR (OSR)
   ) u_tx (
      .i_clk  (i_clk),
      .i_nrst (i_nrst),
      .i_tick (tick),
      .i_load (wr_lo && sel_data),
      .i_data (i_writedata[7:0]),
      .o_line (tx_line),
      .o_busy (tx_busy),
      .o_done (tx_done)
   );

   // Receive shift register
   uart_rx_shift #(
      .OSR (OSR)
   ) u_rx (
      .i_clk   (i_clk),
      .i_nrst  (i_nrst),
      .i_tick  (tick),
      .i_line  (rx_src),
      .o_data  (rx_data),
      .o_valid (rx_valid)
   );

   // Checks
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_nrst);

   AST_DTR_PIN: // R16
      assert property (o_dtr_n == ($past(mcr_reg[B_LOOP]) || !$past(mcr_reg[B_DTR])))
      else $error("terminal ready pin wrong");

   AST_RTS_PIN: // R17
      assert property (mcr_reg[B_RTS] && !loop |=> !o_rts_n)
      else $error("request to send pin not low");

   AST_AUXA_PIN: // R1
      assert property (!loop |=> o_aux_output_a_n == !$past(mcr_reg[B_AUXA]))
      else $error("aux output A wrong");

   AST_PROCESSOR_RESET_OUT_PIN: // R2
      assert property ($rose(mcr_reg[B_AUXA]) |=> o_processor_reset_out)
      else $error("processor reset output not high");

   AST_AUXB_PIN: // R3
      assert property (mcr_reg[B_AUXB] && !loop |=> !o_aux_output_b_n && o_interrupt_pin_oe)
      else $error("aux output B or pin enable wrong");

   AST_INT_HIZ: // R4
      assert property (!mcr_reg[B_AUXB] |=> !o_interrupt_pin_oe)
      else $error("interrupt pin driven while disabled");

   AST_LOOP_PINS: // R5
      assert property (loop |=> o_serial_tx_out && o_dtr_n && o_rts_n
                       && o_aux_output_a_n && o_aux_output_b_n)
      else $error("pins not parked in loopback");

   AST_LOOP_RX: // R7
      assert property (loop && !tx_busy |-> rx_src)
      else $error("receiver not fed from idle transmitter");

   AST_LOOP_MAP: // R18
      assert property (loop && $stable(loop) |=> mstat_reg == $past(
                          {mcr_reg[B_AUXB], mcr_reg[B_AUXA], mcr_reg[B_DTR], mcr_reg[B_RTS]}))
      else $error("loopback status mapping wrong");

   AST_LOOP_IRQ: // R11
      assert property (loop && $stable(loop) && $changed(mcr_reg[B_RTS])
                       |=> delta_reg[0] && irq_reg[I_MODEM])
      else $error("control change raised no modem event");

   AST_RX_IRQ: // R10
      assert property (rx_valid |=> irq_reg[I_RX])
      else $error("receive event lost");

   AST_ZERO_BITS: // R12
      assert property (acc && i_read && sel_mcr |-> rdata_reg[6:5] == 2'b00)
      else $error("dead bits read nonzero");

   AST_PWR_STOP: // R13
      assert property (vmode_reg && mcr_reg[B_PWR] |-> !tick ##1 $stable(div_reg))
      else $error("oscillator runs in shutdown");

   AST_PWR_WAKE: // R15
      assert property (!mcr_reg[B_PWR] [*2] |-> ##[0:64] tick)
      else $error("port did not restart");

   // Reset pin, interrupt, shutdown and register checks
   AST_PROCESSOR_RESET_OUT_LOW: // R2
      assert property ($fell(mcr_reg[B_AUXA]) |=> !o_processor_reset_out)
      else $error("processor reset output not low");

   AST_IRQ_LEVEL: // R10
      assert property (irq_reg[I_RX] && mask_reg[I_RX] |=> o_irq && o_interrupt_pin_o)
      else $error("unmasked event raised no interrupt");

   AST_TX_IRQ: // R10
      assert property (tx_done |=> irq_reg[I_TX])
      else $error("transmit event lost");

   AST_MODEM_IRQ: // R11
      assert property (|delta_ev |=> irq_reg[I_MODEM])
      else $error("modem change event lost");

   AST_SHUT_HOLD: // R14
      assert property (vmode_reg && mcr_reg[B_PWR] && !acc
                       |=> $stable(mcr_reg) && $stable(mask_reg) && $stable(rx_data))
      else $error("register changed in shutdown");

   AST_SHUT_QUIET: // R13
      assert property (vmode_reg && mcr_reg[B_PWR] |=> !rx_valid && !tx_done)
      else $error("serial activity in shutdown");

   AST_DEAD_BITS: // R19
      assert property (mcr_reg[6:5] == 2'h0)
      else $error("dead control bits stored");

   AST_MSR_PINS: // R8
      assert property (!loop |=> mstat_reg == ~$past(filt_reg[4:1]))
      else $error("status not taken from pins");
endmodule

// ===== logic/uart_rx_shift.sv
// Receive shift register: samples mid-bit, 8 data bits, one stop bit
`timescale 1ns/1ps
module uart_rx_shift #(
   parameter int unsigned OSR = 16
) (
   // Clock, reset and oversample enable
   input  wire logic       i_clk,
   input  wire logic       i_nrst,
   input  wire logic       i_tick,
   // Serial line
   input  wire logic       i_line,
   // Received character
   output logic [7:0]      o_data,
   output logic            o_valid
);
   localparam int unsigned CW = $clog2(OSR);

   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;

   generate
      if (OSR < 2) begin : g_chk
         $error("OSR must be at least 2");
      end
   endgenerate

   rx_state_t     st_reg;
   logic [CW-1:0] os_reg;
   logic [2:0]    cnt_reg;
   logic [7:0]    sh_reg;
   logic          half;
   logic          full;

   // Sample points within a bit
   assign half = (os_reg == CW'(OSR / 2 - 1));
   assign full = (os_reg == CW'(OSR - 1));

   // Frame state machine
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         st_reg  <= RX_IDLE;
         os_reg  <= '0;
         cnt_reg <= 3'h0;
         sh_reg  <= 8'h00;
         o_data  <= 8'h00;
         o_valid <= 1'b0;
      end else begin
         o_valid <= 1'b0;
         if (i_tick) begin
            os_reg <= os_reg + CW'(1);
            case (st_reg)
               RX_IDLE: begin
                  os_reg <= '0;
                  if (!i_line) st_reg <= RX_START;
               end
               RX_START: begin
                  if (half) begin
                     os_reg  <= '0;
                     cnt_reg <= 3'h0;
                     st_reg  <= i_line ? RX_IDLE : RX_DATA;
                  end
               end
               RX_DATA: begin
                  if (full) begin
                     sh_reg  <= {i_line, sh_reg[7:1]};
                     cnt_reg <= cnt_reg + 3'h1;
                     if (cnt_reg == 3'h7) st_reg <= RX_STOP;
                  end
               end
               RX_STOP: begin
                  if (full) begin
                     o_data  <= sh_reg;
                     o_valid <= i_line;
                     st_reg  <= RX_IDLE;
                  end
               end
               default: st_reg <= RX_IDLE;
            endcase
         end
      end
   end
endmodule

// ===== logic/uart_tx_shift.sv
// Transmit shift register: start bit, 8 data bits LSB first, one stop bit
`timescale 1ns/1ps
module uart_tx_shift #(
   parameter int unsigned OSR = 16
) (
   // Clock, reset and oversample enable
   input  wire logic       i_clk,
   input  wire logic       i_nrst,
   input  wire logic       i_tick,
   // Character load
   input  wire logic       i_load,
   input  wire logic [7:0] i_data,
   // Serial line and status
   output logic            o_line,
   output logic            o_busy,
   output logic            o_done
);
   localparam int unsigned CW = $clog2(OSR);

   logic [CW-1:0] os_reg;
   logic [3:0]    bit_reg;
   logic [9:0]    sh_reg;
   logic          bit_end;

   generate
      if (OSR < 2) begin : g_chk
         $error("OSR must be at least 2");
      end
   endgenerate

   // Bit time end and busy state
   assign bit_end = i_tick && (os_reg == CW'(OSR - 1));
   assign o_busy  = (bit_reg != 4'h0);
   assign o_line  = sh_reg[0];

   // Load a frame, then shift one bit per bit time
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         os_reg  <= '0;
         bit_reg <= 4'h0;
         sh_reg  <= 10'h3FF;
         o_done  <= 1'b0;
      end else begin
         o_done <= 1'b0;
         if (!o_busy && i_load) begin
            sh_reg  <= {1'b1, i_data, 1'b0};
            bit_reg <= 4'hA;
            os_reg  <= '0;
         end else if (o_busy && i_tick) begin
            os_reg <= bit_end ? '0 : os_reg + CW'(1);
            if (bit_end) begin
               sh_reg  <= {1'b1, sh_reg[9:1]};
               bit_reg <= bit_reg - 4'h1;
               o_done  <= (bit_reg == 4'h1);
            end
         end
      end
   end
endmodule

// ===== tb/modem_model.sv
// Modem-side model: drives the status pins and sends 8N1 characters
`timescale 1ns/1ps
module modem_model #(
   parameter int unsigned BIT_CYC = 16
) (
   // Clock and commands from the bench
   input  wire logic       i_clk,
   input  wire logic [3:0] i_status_n,
   input  wire logic       i_break,
   input  wire logic       i_send,
   input  wire logic [7:0] i_char,
   // Pins toward the device
   output logic            o_rx,
   output logic            o_cts_n,
   output logic            o_dsr_n,
   output logic            o_ri_n,
   output logic            o_dcd_n
);
   logic [9:0] frame_reg = 10'h3FF;
   int         bit_cnt = 0;
   int         cyc_cnt = 0;
   // Status pins follow the bench request
   assign {o_dcd_n, o_ri_n, o_dsr_n, o_cts_n} = i_status_n;
   // Line idles at mark, or holds space while a break is asked
   assign o_rx = (bit_cnt > 0) ? frame_reg[0] : ~i_break;
   // Frame shifter: start bit, data LSB first, stop bit
   always @(posedge i_clk) begin
      if (bit_cnt == 0 && i_send) begin
         frame_reg <= {1'b1, i_char, 1'b0};
         bit_cnt <= 10;
         cyc_cnt <= BIT_CYC - 1;
      end else if (bit_cnt > 0 && cyc_cnt == 0) begin
         frame_reg <= frame_reg >> 1;
         bit_cnt <= bit_cnt - 1;
         cyc_cnt <= BIT_CYC - 1;
      end else if (bit_cnt > 0) begin
         cyc_cnt <= cyc_cnt - 1;
      end
   end
endmodule

// ===== tb/tb_uart_modem_ctrl_loopback.sv
// Self-checking bench for the modem control block
`timescale 1ns/1ps
module tb_uart_modem_ctrl_loopback;
   import uart_mcr_pkg::*;
   logic        i_clk = 1'b0;
   logic        i_nrst = 1'b0;
   logic [2:0]  i_address = 3'h0;
   logic        i_read = 1'b0;
   logic        i_write = 1'b0;
   logic [31:0] i_writedata = 32'h0;
   logic [3:0]  i_byteenable = 4'h1;
   logic [31:0] o_readdata;
   logic        o_waitrequest, o_irq, o_serial_tx_out, o_dtr_n, o_rts_n;
   logic        o_aux_output_a_n, o_aux_output_b_n, o_processor_reset_out;
   logic        o_interrupt_pin_o, o_interrupt_pin_oe;
   logic        rx, cts_n, dsr_n, ri_n, dcd_n;
   logic [3:0]  st_n = 4'hF;
   logic        brk = 1'b0;
   logic        send = 1'b0;
   logic [7:0]  ch = 8'h00;
   logic [31:0] exp_q[$];
   int          n_mismatch = 0;
   int          total_checks = 0;

   // Clock at 200 MHz
   always #2.5 i_clk = ~i_clk;

   uart_modem_ctrl_loopback #(.BAUD_DIV(2)) u_uart_modem_ctrl_loopback (
      .i_clk(i_clk), .i_nrst(i_nrst), .i_address(i_address), .i_read(i_read),
      .i_write(i_write), .i_writedata(i_writedata), .i_byteenable(i_byteenable),
      .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .o_irq(o_irq),
      .i_serial_rx_in(rx), .i_cts_n(cts_n), .i_dsr_n(dsr_n), .i_ri_n(ri_n),
      .i_dcd_n(dcd_n), .o_serial_tx_out(o_serial_tx_out), .o_dtr_n(o_dtr_n),
      .o_rts_n(o_rts_n), .o_aux_output_a_n(o_aux_output_a_n),
      .o_aux_output_b_n(o_aux_output_b_n), .o_processor_reset_out(o_processor_reset_out),
      .o_interrupt_pin_o(o_interrupt_pin_o), .o_interrupt_pin_oe(o_interrupt_pin_oe));

   modem_model #(.BIT_CYC(32)) u_modem_model (
      .i_clk(i_clk), .i_status_n(st_n), .i_break(brk), .i_send(send), .i_char(ch),
      .o_rx(rx), .o_cts_n(cts_n), .o_dsr_n(dsr_n), .o_ri_n(ri_n), .o_dcd_n(dcd_n));

   // Pseudo-random source for control values
   function automatic logic [7:0] lfsr(input logic [7:0] x);
      return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      total_checks++;
      if (seen !== want) begin
         n_mismatch++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // Avalon write: hold until waitrequest is seen low
   task automatic bus_write(input logic [2:0] a, input logic [7:0] d);
      @(posedge i_clk);
      i_address <= a;
      i_writedata <= {24'h000000, d};
      i_write <= 1'b1;
      do @(posedge i_clk); while (o_waitrequest !== 1'b0);
      i_write <= 1'b0;
   endtask

   // Avalon read: expectation queued, monitor compares
   task automatic bus_read(input logic [2:0] a, input logic [7:0] e);
      exp_q.push_back({24'h000000, e});
      @(posedge i_clk);
      i_address <= a;
      i_read <= 1'b1;
      do @(posedge i_clk); while (o_waitrequest !== 1'b0);
      i_read <= 1'b0;
   endtask

   // Pin group: dtr, rts, aux a, aux b, reset out, irq enable, tx
   task automatic pins(input logic [6:0] e);
      repeat (2) @(posedge i_clk);
      check({25'h0, o_dtr_n, o_rts_n, o_aux_output_a_n, o_aux_output_b_n,
             o_processor_reset_out, o_interrupt_pin_oe, o_serial_tx_out}, {25'h0, e});
   endtask

   // Bounded wait for the interrupt, watching tx stays high
   task automatic wait_irq(output logic tx_hi);
      int k;
      tx_hi = 1'b1;
      k = 0;
      while (o_irq !== 1'b1 && k < 600) begin
         @(posedge i_clk);
         if (o_serial_tx_out !== 1'b1) tx_hi = 1'b0;
         k++;
      end
      check({31'h0, o_irq}, 32'h1);
   endtask

   // Read result monitor, oldest note first
   always @(posedge i_clk) begin
      if (i_read && o_waitrequest === 1'b0) begin
         check(o_readdata, exp_q.pop_front());
      end
   end

   // Watchdog
   initial begin
      repeat (20000) @(posedge i_clk);
      n_mismatch++;
      tally_and_finish();
   end

   // Main sequence
   initial begin
      logic [7:0] r;
      logic       ok;
      int         k;
      r = 8'h4F;
      repeat (4) @(posedge i_clk);
      i_nrst <= 1'b1;
      @(posedge i_clk);
      pins(7'h79);
      bus_read(OFS_MSR, 8'h00);
      // Random settings of the four control bits
      for (k = 0; k < 8; k++) begin
         r = lfsr(r);
         bus_write(OFS_MCR, {4'h0, r[3:0]});
         pins({~r[0], ~r[1], ~r[2], ~r[3], r[2], r[3], 1'b1});
         bus_read(OFS_MCR, {4'h0, r[3:0]});
      end
      // Always-zero bits and an unmapped word
      bus_write(OFS_MCR, 8'hE0);
      bus_read(OFS_MCR, 8'h80);
      bus_write(OFS_MCR, 8'h00);
      bus_write(3'h6, 8'hFF);
      bus_read(3'h6, 8'h00);
      // Loopback: parked pins, control bits seen as status
      bus_write(OFS_MCR, 8'h1F);
      pins(7'h7F);
      bus_read(OFS_MSR, 8'hFB);
      bus_read(OFS_IRQ_STAT, 8'h01);
      bus_write(OFS_IRQ_MASK, 8'h01);
      repeat (2) @(posedge i_clk);
      check({31'h0, o_irq}, 32'h1);
      st_n <= 4'h0;
      brk <= 1'b1;
      bus_write(OFS_MCR, 8'h10);
      repeat (10) @(posedge i_clk);
      bus_read(OFS_MSR, 8'h0F);
      bus_write(OFS_IRQ_STAT, 8'h07);
      bus_write(OFS_IRQ_MASK, 8'h02);
      bus_write(OFS_DATA, 8'hA5);
      wait_irq(ok);
      check({31'h0, ok}, 32'h1);
      bus_read(OFS_DATA, 8'hA5);
      // Normal reception from the modem side
      st_n <= 4'hF;
      brk <= 1'b0;
      bus_write(OFS_MCR, 8'h00);
      repeat (40) @(posedge i_clk);
      bus_write(OFS_IRQ_STAT, 8'h07);
      @(posedge i_clk);
      send <= 1'b1;
      ch <= 8'h3C;
      @(posedge i_clk);
      send <= 1'b0;
      wait_irq(ok);
      bus_read(OFS_DATA, 8'h3C);
      // Power shutdown in vendor mode, then wake
      bus_write(OFS_CFG, 8'h01);
      bus_write(OFS_MCR, 8'h83);
      bus_write(OFS_DATA, 8'hC3);
      // Frame freezes on its start bit while the oscillator is stopped
      repeat (2) @(posedge i_clk);
      ok = 1'b1;
      repeat (200) begin
         @(posedge i_clk);
         if (o_serial_tx_out !== 1'b0) ok = 1'b0;
      end
      check({31'h0, ok}, 32'h1);
      bus_read(OFS_MCR, 8'h83);
      bus_write(OFS_MCR, 8'h03);
      k = 0;
      while (o_serial_tx_out !== 1'b1 && k < 100) begin
         @(posedge i_clk);
         k++;
      end
      check({31'h0, o_serial_tx_out}, 32'h1);
      repeat (4) @(posedge i_clk);
      tally_and_finish();
   end
endmodule
